// [sdpi_pkg.sv]
/*
  Shared constants and types of the memory pin interface.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package sdpi_pkg;
  localparam int ADDR_W = 16;
  localparam int BANK_W = 3;
  localparam int RANKS = 2;
  localparam int DQ_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES = 2;
  localparam int BURST_WORDS = 2;
  // link clock period and read capture timeout
  localparam int LINK_PERIOD_NS = 32;
  localparam int RD_TIMEOUT_NS = 640;
  localparam int RD_TIMEOUT_CYC = RD_TIMEOUT_NS / LINK_PERIOD_NS;
  // reset values of the pins
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [2:0] BANK_RST = 3'h0;
  // pin encodings {select_n, row_n, col_n, we_n}
  localparam logic [3:0] ENC_NOP = 4'h7;
  localparam logic [3:0] ENC_ACT = 4'h3;
  localparam logic [3:0] ENC_RD = 4'h5;
  localparam logic [3:0] ENC_WR = 4'h4;
  localparam logic [3:0] ENC_PRE = 4'h2;
  localparam logic [3:0] ENC_REF = 4'h1;
  localparam logic [3:0] ENC_MRS = 4'h0;
  typedef enum logic [2:0] {
    SDPI_NOP = 3'h0,
    SDPI_ACT = 3'h1,
    SDPI_RD = 3'h2,
    SDPI_WR = 3'h3,
    SDPI_PRE = 3'h4,
    SDPI_REF = 3'h5,
    SDPI_MRS = 3'h6
  } sdpi_cmd_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CMD = 5'h02,
    ST_WR = 5'h04,
    ST_RD = 5'h08,
    ST_ACK = 5'h10
  } sdpi_state_t;
endpackage
`default_nettype wire

// [sdpi_sync.sv]
/*
  Two-flop synchroniser for a group of independent levels.
  Assumes each bit is a level or a toggle that stays put long enough.
*/
`timescale 1ns/1ps
`default_nettype none
module sdpi_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [sdpi_byte_lane.sv]
/*
  One byte lane: data, mask and strobe pair, driven on writes and
  captured by strobe edges on reads.
  Assumes linkClk is the link domain clock; pins arrive asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
module sdpi_byte_lane #(
  parameter int W = 8
) (
  input wire logic linkClk,
  input wire logic nrst,
  input wire logic drvEn,
  input wire logic wordSel,
  input wire logic [W-1:0] wrWord0,
  input wire logic [W-1:0] wrWord1,
  input wire logic mask0,
  input wire logic mask1,
  input wire logic capEn,
  input wire logic [W-1:0] dqIn,
  output logic [W-1:0] dqOut,
  output logic [W-1:0] dqOe,
  input wire logic dqsIn,
  output logic dqsOut,
  output logic dqsOe,
  output logic dqsCompOut,
  output logic dqsCompOe,
  output logic maskOut,
  output logic [W-1:0] capWord0,
  output logic [W-1:0] capWord1,
  output logic capDone
);
  logic [W-1:0] dqMeta_r, dqSync_r;
  logic dqsMeta_r, dqsSync_r, dqsPrev_r;
  logic gotRise_r, gotFall_r;

  initial begin
    if (W < 1) $error("lane width must be positive");
  end

  // ==========================================================
  // write side
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      dqOut <= '0;
      dqOe <= '0;
      dqsOut <= 1'b0;
      dqsCompOut <= 1'b1;
      dqsOe <= 1'b0;
      dqsCompOe <= 1'b0;
      maskOut <= 1'b0;
    end else begin
      dqOut <= drvEn ? (wordSel ? wrWord1 : wrWord0) : '0;
      dqOe <= {W{drvEn}};
      dqsOut <= drvEn & ~wordSel;
      dqsCompOut <= ~(drvEn & ~wordSel);
      dqsOe <= drvEn;
      dqsCompOe <= drvEn;
      maskOut <= drvEn & (wordSel ? mask1 : mask0);
    end
  end

  // ==========================================================
  // read capture: data and strobe delayed alike
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      dqMeta_r <= '0;
      dqSync_r <= '0;
      dqsMeta_r <= 1'b0;
      dqsSync_r <= 1'b0;
      dqsPrev_r <= 1'b0;
    end else begin
      dqMeta_r <= dqIn;
      dqSync_r <= dqMeta_r;
      dqsMeta_r <= dqsIn;
      dqsSync_r <= dqsMeta_r;
      dqsPrev_r <= dqsSync_r;
    end
  end

  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      capWord0 <= '0;
      capWord1 <= '0;
      gotRise_r <= 1'b0;
      gotFall_r <= 1'b0;
      capDone <= 1'b0;
    end else if (!capEn) begin
      gotRise_r <= 1'b0;
      gotFall_r <= 1'b0;
      capDone <= 1'b0;
    end else begin
      if (dqsSync_r && !dqsPrev_r && !gotRise_r) begin
        capWord0 <= dqSync_r;
        gotRise_r <= 1'b1;
      end
      if (!dqsSync_r && dqsPrev_r && gotRise_r && !gotFall_r) begin
        capWord1 <= dqSync_r;
        gotFall_r <= 1'b1;
      end
      capDone <= gotRise_r & gotFall_r;
    end
  end
endmodule
`default_nettype wire

// [sdpi_top.sv]
/*
  Pin interface to a 16-bit double-data-rate memory: command issue,
  memory clock, byte lanes, termination and clock enable.
  Assumes the user port is on clk and linkClk is an unrelated clock
  from which the memory clock is divided.
*/
`timescale 1ns/1ps
`default_nettype none
module sdpi_top #(
  parameter int RD_TIMEOUT = sdpi_pkg::RD_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic linkClk,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [2:0] cmdCode,
  input wire logic cmdRank,
  input wire logic [2:0] cmdBank,
  input wire logic [15:0] cmdAddr,
  input wire logic [31:0] wrData,
  input wire logic [3:0] wrMask,
  input wire logic ckeOn,
  input wire logic odtOn,
  output logic rdValid,
  output logic [31:0] rdData,
  output logic rdTimeout,
  output logic [15:0] memAddr,
  output logic [2:0] memBank,
  output logic memClkTrue,
  output logic memClkComp,
  output logic memClkEn,
  output logic [1:0] memRankSelN,
  output logic memRowStrobeN,
  output logic memColStrobeN,
  output logic memWriteEnN,
  output logic memTermCtrl,
  output logic memMaskLo,
  output logic memMaskHi,
  input wire logic [15:0] memDataIn,
  output logic [15:0] memDataOut,
  output logic [15:0] memDataOe,
  input wire logic memStrobeLoIn,
  output logic memStrobeLoOut,
  output logic memStrobeLoOe,
  input wire logic memStrobeLoCompIn,
  output logic memStrobeLoCompOut,
  output logic memStrobeLoCompOe,
  input wire logic memStrobeHiIn,
  output logic memStrobeHiOut,
  output logic memStrobeHiOe,
  input wire logic memStrobeHiCompIn,
  output logic memStrobeHiCompOut,
  output logic memStrobeHiCompOe
);
  localparam int LW = sdpi_pkg::LANE_W;

  initial begin
    if (RD_TIMEOUT < 1 || RD_TIMEOUT > 255) $error("read timeout out of range");
    if (sdpi_pkg::LANES * LW != sdpi_pkg::DQ_W) $error("lane split mismatch");
  end

  // ==========================================================
  // user side (clk domain)
  logic reqTgl_r, ackPrev_r, ackSync;
  logic [2:0] holdCode_r;
  logic holdRank_r;
  logic [2:0] holdBank_r;
  logic [15:0] holdAddr_r;
  logic [31:0] holdWr_r;
  logic [3:0] holdMask_r;
  logic ackTgl_r;
  logic [31:0] rdHold_r;
  logic rdTo_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmdReady <= 1'b1;
      reqTgl_r <= 1'b0;
      ackPrev_r <= 1'b0;
      holdCode_r <= sdpi_pkg::SDPI_NOP;
      holdRank_r <= 1'b0;
      holdBank_r <= sdpi_pkg::BANK_RST;
      holdAddr_r <= sdpi_pkg::ADDR_RST;
      holdWr_r <= 32'h0000_0000;
      holdMask_r <= 4'h0;
      rdValid <= 1'b0;
      rdData <= 32'h0000_0000;
      rdTimeout <= 1'b0;
    end else begin
      ackPrev_r <= ackSync;
      rdValid <= 1'b0;
      if (cmdValid && cmdReady) begin
        holdCode_r <= cmdCode;
        holdRank_r <= cmdRank;
        holdBank_r <= cmdBank;
        holdAddr_r <= cmdAddr;
        holdWr_r <= wrData;
        holdMask_r <= wrMask;
        reqTgl_r <= ~reqTgl_r;
        cmdReady <= 1'b0;
      end else if (ackSync != ackPrev_r) begin
        cmdReady <= 1'b1;
        if (holdCode_r == sdpi_pkg::SDPI_RD) begin
          rdValid <= 1'b1;
          rdData <= rdHold_r;
          rdTimeout <= rdTo_r;
        end
      end
    end
  end

  sdpi_sync #(.W(1)) ackSyncU (
    .clk(clk),
    .nrst(nrst),
    .d(ackTgl_r),
    .q(ackSync)
  );

  // ==========================================================
  // link side (linkClk domain)
  logic [2:0] linkSync;
  logic reqPrev_r, pend_r;
  logic cntBit_r;
  logic [7:0] toCnt_r;
  logic drvEn, capEn;
  logic [1:0] capDone;
  logic [LW-1:0] cap0Lo, cap1Lo, cap0Hi, cap1Hi;
  logic [3:0] enc;
  sdpi_pkg::sdpi_state_t state_r;
  wire logic reqSync = linkSync[0];
  wire logic issue = (state_r == sdpi_pkg::ST_IDLE) && pend_r && !memClkTrue;

  sdpi_sync #(.W(3)) linkSyncU (
    .clk(linkClk),
    .nrst(nrst),
    .d({odtOn, ckeOn, reqTgl_r}),
    .q(linkSync)
  );

  // memory clock, one half period per link cycle
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      memClkTrue <= 1'b0;
      memClkComp <= 1'b1;
      memClkEn <= 1'b0;
    end else begin
      memClkTrue <= ~memClkTrue;
      memClkComp <= memClkTrue;
      memClkEn <= linkSync[1];
    end
  end

  // command truth table
  always_comb begin
    case (holdCode_r)
      sdpi_pkg::SDPI_ACT: enc = sdpi_pkg::ENC_ACT;
      sdpi_pkg::SDPI_RD: enc = sdpi_pkg::ENC_RD;
      sdpi_pkg::SDPI_WR: enc = sdpi_pkg::ENC_WR;
      sdpi_pkg::SDPI_PRE: enc = sdpi_pkg::ENC_PRE;
      sdpi_pkg::SDPI_REF: enc = sdpi_pkg::ENC_REF;
      sdpi_pkg::SDPI_MRS: enc = sdpi_pkg::ENC_MRS;
      default: enc = sdpi_pkg::ENC_NOP;
    endcase
  end

  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      reqPrev_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      reqPrev_r <= reqSync;
      if (reqSync != reqPrev_r) begin
        pend_r <= 1'b1;
      end else if (issue) begin
        pend_r <= 1'b0;
      end
    end
  end

  // sequencer
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      state_r <= sdpi_pkg::ST_IDLE;
      cntBit_r <= 1'b0;
      toCnt_r <= 8'h00;
      ackTgl_r <= 1'b0;
    end else begin
      case (state_r)
        sdpi_pkg::ST_IDLE: begin
          cntBit_r <= 1'b0;
          if (issue) begin
            state_r <= sdpi_pkg::ST_CMD;
          end
        end
        sdpi_pkg::ST_CMD: begin
          cntBit_r <= ~cntBit_r;
          if (cntBit_r) begin
            cntBit_r <= 1'b0;
            toCnt_r <= 8'h00;
            if (holdCode_r == sdpi_pkg::SDPI_WR) begin
              state_r <= sdpi_pkg::ST_WR;
            end else if (holdCode_r == sdpi_pkg::SDPI_RD) begin
              state_r <= sdpi_pkg::ST_RD;
            end else begin
              state_r <= sdpi_pkg::ST_ACK;
            end
          end
        end
        sdpi_pkg::ST_WR: begin
          cntBit_r <= ~cntBit_r;
          if (cntBit_r) begin
            state_r <= sdpi_pkg::ST_ACK;
          end
        end
        sdpi_pkg::ST_RD: begin
          toCnt_r <= toCnt_r + 8'h01;
          if (&capDone || toCnt_r == 8'(RD_TIMEOUT - 1)) begin
            state_r <= sdpi_pkg::ST_ACK;
          end
        end
        sdpi_pkg::ST_ACK: begin
          ackTgl_r <= ~ackTgl_r;
          state_r <= sdpi_pkg::ST_IDLE;
        end
        default: state_r <= sdpi_pkg::ST_IDLE;
      endcase
    end
  end

  // read result held for the user side
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      rdHold_r <= 32'h0000_0000;
      rdTo_r <= 1'b0;
    end else if (state_r == sdpi_pkg::ST_RD) begin
      rdHold_r <= {cap1Hi, cap1Lo, cap0Hi, cap0Lo};
      rdTo_r <= ~&capDone;
    end
  end

  // command pins, held one memory clock
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      memAddr <= sdpi_pkg::ADDR_RST;
      memBank <= sdpi_pkg::BANK_RST;
      memRankSelN <= 2'h3;
      memRowStrobeN <= 1'b1;
      memColStrobeN <= 1'b1;
      memWriteEnN <= 1'b1;
    end else if (issue) begin
      memAddr <= holdAddr_r;
      memBank <= holdBank_r;
      memRankSelN <= holdRank_r ? {enc[3], 1'b1} : {1'b1, enc[3]};
      memRowStrobeN <= enc[2];
      memColStrobeN <= enc[1];
      memWriteEnN <= enc[0];
    end else if (state_r == sdpi_pkg::ST_CMD && cntBit_r) begin
      memRankSelN <= 2'h3;
      memRowStrobeN <= 1'b1;
      memColStrobeN <= 1'b1;
      memWriteEnN <= 1'b1;
    end
  end

  // termination on through the write command and burst
  always_ff @(posedge linkClk or negedge nrst) begin
    if (!nrst) begin
      memTermCtrl <= 1'b0;
    end else begin
      memTermCtrl <= linkSync[2] && holdCode_r == sdpi_pkg::SDPI_WR &&
        (state_r == sdpi_pkg::ST_CMD || state_r == sdpi_pkg::ST_WR);
    end
  end

  // ==========================================================
  // byte lanes
  assign drvEn = (state_r == sdpi_pkg::ST_WR);
  assign capEn = (state_r == sdpi_pkg::ST_RD);

  sdpi_byte_lane #(.W(LW)) laneLo (
    .linkClk(linkClk),
    .nrst(nrst),
    .drvEn(drvEn),
    .wordSel(cntBit_r),
    .wrWord0(holdWr_r[7:0]),
    .wrWord1(holdWr_r[23:16]),
    .mask0(holdMask_r[0]),
    .mask1(holdMask_r[2]),
    .capEn(capEn),
    .dqIn(memDataIn[7:0]),
    .dqOut(memDataOut[7:0]),
    .dqOe(memDataOe[7:0]),
    .dqsIn(memStrobeLoIn),
    .dqsOut(memStrobeLoOut),
    .dqsOe(memStrobeLoOe),
    .dqsCompOut(memStrobeLoCompOut),
    .dqsCompOe(memStrobeLoCompOe),
    .maskOut(memMaskLo),
    .capWord0(cap0Lo),
    .capWord1(cap1Lo),
    .capDone(capDone[0])
  );

  sdpi_byte_lane #(.W(LW)) laneHi (
    .linkClk(linkClk),
    .nrst(nrst),
    .drvEn(drvEn),
    .wordSel(cntBit_r),
    .wrWord0(holdWr_r[15:8]),
    .wrWord1(holdWr_r[31:24]),
    .mask0(holdMask_r[1]),
    .mask1(holdMask_r[3]),
    .capEn(capEn),
    .dqIn(memDataIn[15:8]),
    .dqOut(memDataOut[15:8]),
    .dqOe(memDataOe[15:8]),
    .dqsIn(memStrobeHiIn),
    .dqsOut(memStrobeHiOut),
    .dqsOe(memStrobeHiOe),
    .dqsCompOut(memStrobeHiCompOut),
    .dqsCompOe(memStrobeHiCompOe),
    .maskOut(memMaskHi),
    .capWord0(cap0Hi),
    .capWord1(cap1Hi),
    .capDone(capDone[1])
  );
endmodule
`default_nettype wire

// [sdpi_properties.sv]
/*
  Pin-level checker for the memory pin interface, bound to sdpi_top.
  Assumes every memory pin is a flop on linkClk.
*/
`timescale 1ns/1ps
`default_nettype none
module sdpi_properties #(
  parameter int RD_TIMEOUT = 20
) (
  input wire logic linkClk,
  input wire logic nrst,
  input wire logic memClkTrue,
  input wire logic memClkComp,
  input wire logic [1:0] memRankSelN,
  input wire logic memRowStrobeN,
  input wire logic memColStrobeN,
  input wire logic memWriteEnN,
  input wire logic memMaskLo,
  input wire logic memMaskHi,
  input wire logic [15:0] memDataOe,
  input wire logic memStrobeLoOut,
  input wire logic memStrobeLoOe,
  input wire logic memStrobeLoCompOut,
  input wire logic memStrobeLoCompOe,
  input wire logic memStrobeHiOut,
  input wire logic memStrobeHiOe,
  input wire logic memStrobeHiCompOut,
  input wire logic memStrobeHiCompOe
);
  default clocking cb @(posedge linkClk);
  endclocking
  default disable iff (!nrst);
  wire [2:0] cmdPins = {memRowStrobeN, memColStrobeN, memWriteEnN};
  wire issue = memRankSelN != 2'h3;
  // ==========
  // command and burst shapes
  sequence s_issue;
    issue && !$past(issue);
  endsequence
  sequence s_hold;
    ##1 $stable(memRankSelN) && $stable(cmdPins) ##1 memRankSelN == 2'h3;
  endsequence
  sequence s_burst;
    memStrobeLoOut && memDataOe == 16'hffff ##1 !memStrobeLoOut && memDataOe == 16'hffff
      ##1 memDataOe == 16'h0000;
  endsequence
  // ==========
  // assertions
  clk_pair_a: assert property (memClkComp == !memClkTrue)
    else $error("memory clock pair not complementary");
  clk_toggle_a: assert property (1'b1 |=> memClkTrue != $past(memClkTrue))
    else $error("memory clock stalled");
  rank_single_a: assert property (memRankSelN != 2'h0)
    else $error("both ranks selected");
  cmd_edge_a: assert property (s_issue |-> $rose(memClkTrue))
    else $error("command not on memory clock rise");
  cmd_hold_a: assert property (s_issue |-> s_hold)
    else $error("command not held one memory clock");
  wr_drive_a: assert property (s_issue ##0 cmdPins == 3'h4 |->
    ##1 (memDataOe == 16'h0000)[*2] ##1 s_burst)
    else $error("write burst shape wrong");
  rd_release_a: assert property (s_issue ##0 cmdPins == 3'h5 |->
    ##1 (memDataOe == 16'h0000 && !memStrobeLoOe && !memStrobeHiOe)[*8])
    else $error("device drives bus during read");
  mask_write_a: assert property (memMaskLo || memMaskHi |-> memDataOe == 16'hffff)
    else $error("mask outside write data");
  strobe_lane_a: assert property (memStrobeLoOe == memDataOe[0] &&
    memStrobeHiOe == memDataOe[8] && memStrobeLoCompOe == memDataOe[0] &&
    memStrobeHiCompOe == memDataOe[8])
    else $error("strobe direction differs from data");
  strobe_pair_a: assert property (memStrobeLoCompOut == !memStrobeLoOut &&
    memStrobeHiCompOut == !memStrobeHiOut && memStrobeHiOut == memStrobeLoOut)
    else $error("strobe pair not complementary");
endmodule
bind sdpi_top sdpi_properties #(.RD_TIMEOUT(RD_TIMEOUT)) u_props (.*);
`default_nettype wire

// [sdpi_mem_model.sv]
/*
  Behavioural memory at the far side: stores writes, answers reads.
  Assumes commands are spaced by the user handshake.
*/
`timescale 1ns/1ps
`default_nettype none
module sdpi_mem_model (
  input wire logic linkClk,
  input wire logic [1:0] memRankSelN,
  input wire logic [2:0] cmdPins,
  input wire logic [2:0] memBank,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] dqOut,
  input wire logic [15:0] dqOe,
  input wire logic stbLo,
  input wire logic stbHi,
  input wire logic maskLo,
  input wire logic maskHi,
  input wire logic [3:0] rdDelay,
  input wire logic mute,
  output logic [15:0] dqDrv,
  output logic stbDrv
);
  bit [31:0] mem [int];
  int key = 0;
  int rdCnt = 0;
  logic [1:0] selPrev = 2'h3;
  logic [31:0] rdWord;
  initial begin
    dqDrv = 16'h0000;
    stbDrv = 1'b0;
  end
  always @(posedge linkClk) begin
    if (selPrev == 2'h3 && memRankSelN != 2'h3) begin
      key = {~memRankSelN[1], memBank, memAddr};
      if (cmdPins == sdpi_pkg::ENC_RD[2:0] && !mute) begin
        rdWord = mem.exists(key) ? mem[key] : 32'h0000_0000;
        rdCnt = rdDelay + 8;
      end
    end else if (rdCnt > 0) begin
      rdCnt--;
    end
    selPrev = memRankSelN;
    if (dqOe[0] && !maskLo) mem[key][(stbLo ? 0 : 16) +: 8] = dqOut[7:0];
    if (dqOe[8] && !maskHi) mem[key][(stbHi ? 8 : 24) +: 8] = dqOut[15:8];
    // word0 with strobe high, word1 with strobe low, else data toggles with strobe low
    if (rdCnt > 4 && rdCnt < 9) begin
      dqDrv <= rdWord[15:0];
      stbDrv <= 1'b1;
    end else if (rdCnt > 0 && rdCnt < 5) begin
      dqDrv <= rdWord[31:16];
      stbDrv <= 1'b0;
    end else begin
      dqDrv <= ~dqDrv;
      stbDrv <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [tb.sv]
/*
  Self-checking bench for sdpi_top with a reference memory.
  Assumes the memory model in sdpi_mem_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, linkClk = 1'b0, nrst = 1'b0, cmdValid = 1'b0, cmdRank = 1'b0;
  logic ckeOn = 1'b0, odtOn = 1'b0, mute = 1'b0, termSeen = 1'b0;
  logic [2:0] cmdCode = 3'h0, cmdBank = 3'h0, encSeen, bankSeen;
  logic [15:0] cmdAddr = 16'h0000, addrSeen, memAddr, memDataOut, memDataOe, mDq;
  logic [31:0] wrData = 32'h0000_0000, rdData;
  logic [3:0] wrMask = 4'h0, rdDelay = 4'h2;
  logic cmdReady, rdValid, rdTimeout, memClkTrue, memClkComp, memClkEn, memRowStrobeN;
  logic memColStrobeN, memWriteEnN, memTermCtrl, memMaskLo, memMaskHi, mStb;
  logic memStrobeLoOut, memStrobeLoOe, memStrobeLoCompOut, memStrobeLoCompOe;
  logic memStrobeHiOut, memStrobeHiOe, memStrobeHiCompOut, memStrobeHiCompOe;
  logic [2:0] memBank;
  logic [1:0] memRankSelN, selSeen;
  wire logic [15:0] memDataIn = (memDataOe & memDataOut) | (~memDataOe & mDq);
  wire logic memStrobeLoIn = memStrobeLoOe ? memStrobeLoOut : mStb;
  wire logic memStrobeHiIn = memStrobeHiOe ? memStrobeHiOut : mStb;
  wire logic memStrobeLoCompIn = ~memStrobeLoIn;
  wire logic memStrobeHiCompIn = ~memStrobeHiIn;
  int num_errors = 0;
  int cmp_count = 0;
  bit [31:0] refMem [int];
  always #12.5 clk = ~clk;
  always #16 linkClk = ~linkClk;
  sdpi_top #(.RD_TIMEOUT(sdpi_pkg::RD_TIMEOUT_CYC)) uut (.*);
  sdpi_mem_model mem (.linkClk(linkClk), .memRankSelN(memRankSelN),
    .cmdPins({memRowStrobeN, memColStrobeN, memWriteEnN}), .memBank(memBank),
    .memAddr(memAddr), .dqOut(memDataOut), .dqOe(memDataOe), .stbLo(memStrobeLoOut),
    .stbHi(memStrobeHiOut), .maskLo(memMaskLo), .maskHi(memMaskHi), .rdDelay(rdDelay),
    .mute(mute), .dqDrv(mDq), .stbDrv(mStb));
  // ==========
  // pin monitor
  always @(posedge linkClk) begin
    if (memRankSelN != 2'h3) begin
      selSeen = memRankSelN;
      encSeen = {memRowStrobeN, memColStrobeN, memWriteEnN};
      addrSeen = memAddr;
      bankSeen = memBank;
    end
    if (memTermCtrl) termSeen = 1'b1;
  end
  // ==========
  // helpers
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      $display("[ERR] %0t %s", $time, m);
      num_errors++;
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  function automatic logic [2:0] enc(input logic [2:0] c);
    case (c)
      3'h1: enc = sdpi_pkg::ENC_ACT[2:0];
      3'h2: enc = sdpi_pkg::ENC_RD[2:0];
      3'h3: enc = sdpi_pkg::ENC_WR[2:0];
      3'h4: enc = sdpi_pkg::ENC_PRE[2:0];
      3'h5: enc = sdpi_pkg::ENC_REF[2:0];
      3'h6: enc = sdpi_pkg::ENC_MRS[2:0];
      default: enc = sdpi_pkg::ENC_NOP[2:0];
    endcase
  endfunction
  task automatic op(input logic [2:0] c, input logic odt);
    logic [31:0] d;
    logic [3:0] m;
    logic [2:0] b;
    logic [15:0] a;
    logic rk;
    logic rv;
    int k;
    int n;
    logic [31:0] expWord;
    d = $urandom;
    m = 4'($urandom);
    b = 3'($urandom % 2);
    a = 16'($urandom % 3);
    rk = 1'($urandom);
    k = {rk, b, a};
    selSeen = 2'h3;
    termSeen = 1'b0;
    rv = 1'b0;
    n = 0;
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdCode <= c;
    cmdRank <= rk;
    cmdBank <= b;
    cmdAddr <= a;
    wrData <= d;
    wrMask <= m;
    odtOn <= odt;
    @(posedge clk);
    cmdValid <= 1'b0;
    do begin
      @(posedge clk);
      #1;
      if (rdValid === 1'b1) rv = 1'b1;
      n++;
    end while (cmdReady !== 1'b1 && n < 300);
    chk(n < 300, "command hang");
    chk(selSeen === (rk ? 2'h1 : 2'h2) && encSeen === enc(c), "command pins");
    chk(addrSeen === a && bankSeen === b, "address or bank");
    chk(termSeen === (c == 3'h3 && odt), "termination");
    if (c == 3'h3) begin
      for (int i = 0; i < 4; i++) if (!m[i]) refMem[k][i*8 +: 8] = d[i*8 +: 8];
    end
    if (c == 3'h2) begin
      expWord = refMem.exists(k) ? refMem[k] : 32'h0000_0000;
      chk(rv === 1'b1 && rdTimeout === mute, "read answer");
      if (!mute) chk(rdData === expWord, "read data");
    end
  endtask
  // ==========
  // sequence
  initial begin
    void'($urandom(2));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (12) @(posedge clk);
    chk(memClkEn === 1'b0, "clock enable high");
    ckeOn <= 1'b1;
    repeat (12) @(posedge clk);
    chk(memClkEn === 1'b1, "clock enable low");
    for (int c = 0; c < 8; c++) op(c[2:0], 1'b1);
    for (int i = 0; i < 40; i++) begin
      rdDelay <= 4'($urandom % 5) + 4'h2;
      op((i % 2) ? 3'h2 : 3'h3, 1'($urandom));
    end
    mute <= 1'b1;
    op(3'h2, 1'b0);
    mute <= 1'b0;
    op(3'h2, 1'b0);
    ckeOn <= 1'b0;
    repeat (12) @(posedge clk);
    chk(memClkEn === 1'b0, "clock enable stuck");
    end_sim;
  end
  // about 50 commands of at most 300 cycles each
  initial begin
    #500000;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
